/* File: design/scan_sched_pkg.sv */
// Package of constants and types for the scan and autocalibration scheduler
package scan_sched_pkg;

	// ==========================================
	// Clock and time base
	localparam int CLK_HZ = 250_000_000;
	localparam int TICK_MS = 1;
	localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
	localparam int CAL_PERIOD_MIN = 5;
	localparam int CAL_PERIOD_MS = CAL_PERIOD_MIN * 60 * 1000;

	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CFG0 = 8'h04;
	localparam logic [7:0] REG_CFG_STEP = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_SCAN_MS = 8'h18;

	// ==========================================
	// Field positions and reset values
	localparam int CTRL_CYC_DIS_BIT = 0;
	localparam logic CTRL_CYC_DIS_RST = 1'b0;
	localparam int CFG_W = 5;
	localparam int CFG_FILT_LSB = 0;
	localparam int CFG_TC_BIT = 3;
	localparam int CFG_EN_BIT = 4;
	localparam logic [4:0] CFG_RST = 5'h00;
	localparam int ST_CAL_BIT = 0;
	localparam int ST_STARTUP_BIT = 1;
	localparam int ST_RUN_BIT = 2;
	localparam int ST_REQ_BIT = 3;
	localparam int ST_HOLD_LSB = 4;
	localparam int ST_INVALID_LSB = 8;
	localparam int ST_CHAN_LSB = 16;
	localparam int NUM_CH = 4;
	localparam int NUM_INVALID = 6;

	// ==========================================
	// Slot kinds and calibration pointer codes
	localparam logic [1:0] KIND_CONV = 2'h0;
	localparam logic [1:0] KIND_CJ = 2'h1;
	localparam logic [1:0] KIND_SELF = 2'h2;
	localparam logic [1:0] KIND_OFFS = 2'h3;
	localparam logic [2:0] PTR_NONE = 3'h4;
	localparam logic [2:0] PTR_CJ = 3'h4;
	localparam logic [2:0] PTR_DONE = 3'h7;

	// ==========================================
	// Millisecond tables, indexed by filter code 0..5 (10, 50, 60, 250, 500, 1k Hz)
	localparam logic [5:0][9:0] SLOT_MS = {10'h007, 10'h009, 10'h00f, 10'h035, 10'h03f, 10'h12f};
	localparam logic [5:0][9:0] SELF_MS = {10'h009, 10'h00f, 10'h01b, 10'h067, 10'h07b, 10'h25b};
	localparam logic [5:0][9:0] OFFS_MS = {10'h006, 10'h009, 10'h00f, 10'h035, 10'h03f, 10'h12f};
	localparam logic [2:0] FILT_MAX = 3'h5;

	typedef enum logic [2:0] {ST_PROG, ST_IDLE, ST_CONV, ST_CJ, ST_CAL} sched_st_t;

	// Undefined filter codes fall back to the slowest filter, the safe choice
	function automatic logic [9:0] ms_of(input logic [5:0][9:0] t, input logic [2:0] f);
		return (f > FILT_MAX) ? t[0] : t[f];
	endfunction

endpackage

/* File: design/ms_tick.sv */
// Restartable millisecond tick generator
`timescale 1ns/1ps
module ms_tick #(
	parameter int P_CYC = scan_sched_pkg::CYC_PER_MS
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_restart,
	output logic o_tick
);
	localparam int W = $clog2(P_CYC + 1);

	typedef struct packed {
		logic [W-1:0] cnt;
	} tick_state_t;

	tick_state_t q;
	tick_state_t n;

	// ==========================================
	// Divider
	assign o_tick = (q.cnt == W'(P_CYC - 1));

	always_comb begin
		n = q;
		if (i_restart || o_tick) begin
			n.cnt = '0;
		end else begin
			n.cnt = q.cnt + W'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule

/* File: design/scan_and_autocal_scheduler.sv */
// Scan sequencer and staggered autocalibration scheduler for four input channels
// ==========================================
`timescale 1ns/1ps
module scan_and_autocal_scheduler #(
	parameter int P_CYC_PER_MS = scan_sched_pkg::CYC_PER_MS,
	parameter int P_CAL_PERIOD_MS = scan_sched_pkg::CAL_PERIOD_MS
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run_mode,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_slot_start,
	output logic [1:0] o_slot_kind,
	output logic [2:0] o_slot_chan,
	output logic [2:0] o_slot_filter,
	output logic o_upd_valid,
	output logic [1:0] o_upd_chan,
	output logic [3:0] o_hold,
	output logic [5:0] o_data_invalid,
	output logic o_cal_busy
);
	typedef struct packed {
		scan_sched_pkg::sched_st_t st;
		logic [2:0] idx;
		logic [9:0] left;
		logic cyc_dis;
		logic [3:0][4:0] cfg;
		logic startup;
		logic cal_act;
		logic cal_req;
		logic [2:0] cal_ch;
		logic cal_ph;
		logic [18:0] cyc_ms;
		logic [3:0] hold;
		logic [15:0] scan_ms;
		logic [15:0] last_scan;
		logic [31:0] rdata;
		logic slot_start;
		logic [1:0] slot_kind;
		logic [2:0] slot_chan;
		logic [2:0] slot_filter;
		logic upd_valid;
		logic [1:0] upd_chan;
	} sched_state_t;

	sched_state_t q;
	sched_state_t n;
	logic tick;
	logic restart;
	logic [3:0] en;
	logic [3:0] tc;
	logic [3:0] need;
	logic any_tc;
	logic [2:0] cj_filt;

	// ==========================================
	// Millisecond time base, restarted at each slot so slots last whole milliseconds
	ms_tick #(.P_CYC(P_CYC_PER_MS)) u_tick (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_restart(restart),
		.o_tick(tick)
	);

	// ==========================================
	// Per-channel decode
	for (genvar g = 0; g < scan_sched_pkg::NUM_CH; g++) begin : g_ch
		logic dup;
		assign en[g] = q.cfg[g][scan_sched_pkg::CFG_EN_BIT];
		assign tc[g] = en[g] && q.cfg[g][scan_sched_pkg::CFG_TC_BIT];
		always_comb begin
			dup = 1'b0;
			for (int j = 0; j < g; j++) begin
				if (en[j] && q.cfg[j][2:0] == q.cfg[g][2:0]) begin
					dup = 1'b1;
				end
			end
		end
		assign need[g] = en[g] && !dup;
	end

	assign any_tc = |tc;

	// Lowest filter frequency is the lowest code among thermocouple channels
	always_comb begin
		logic [2:0] f;
		cj_filt = scan_sched_pkg::FILT_MAX;
		f = '0;
		for (int i = 0; i < scan_sched_pkg::NUM_CH; i++) begin
			f = (q.cfg[i][2:0] > scan_sched_pkg::FILT_MAX) ? 3'h0 : q.cfg[i][2:0];
			if (tc[i] && f < cj_filt) begin
				cj_filt = f;
			end
		end
	end

	function automatic logic [2:0] first_from(input logic [3:0] m, input logic [2:0] from);
		logic [2:0] r;
		r = scan_sched_pkg::PTR_NONE;
		for (int i = 3; i >= 0; i--) begin
			if (m[i] && 3'(i) >= from) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// Next calibration target at or after from; cold junction last, then done
	function automatic logic [2:0] next_cal(input logic [3:0] m, input logic t, input logic [2:0] from);
		logic [2:0] r;
		r = first_from(m, from);
		if (r == scan_sched_pkg::PTR_NONE) begin
			r = t ? scan_sched_pkg::PTR_CJ : scan_sched_pkg::PTR_DONE;
		end
		return r;
	endfunction

	// ==========================================
	// Sequencer
	always_comb begin
		logic step_end;
		logic to_next;
		logic to_eos;
		logic to_cal;
		logic to_scan;
		logic launch;
		logic [1:0] lk;
		logic [2:0] lch;
		logic [2:0] lf;
		logic [2:0] c;
		n = q;
		step_end = tick && q.left == 10'h001;
		to_next = 1'b0;
		to_eos = 1'b0;
		to_cal = 1'b0;
		to_scan = 1'b0;
		launch = 1'b0;
		lk = scan_sched_pkg::KIND_CONV;
		lch = '0;
		lf = '0;
		c = '0;
		n.slot_start = 1'b0;
		n.upd_valid = 1'b0;
		n.rdata = '0;
		if (tick) begin
			n.left = q.left - 10'h001;
			if (q.scan_ms != 16'hffff) begin
				n.scan_ms = q.scan_ms + 16'h0001;
			end
		end

		if (!i_run_mode) begin
			n.st = scan_sched_pkg::ST_PROG;
			n.startup = 1'b0;
			n.cal_act = 1'b0;
		end else begin
			case (q.st)
				scan_sched_pkg::ST_PROG: begin
					// Entering run starts a full calibration whatever the cyclic setting
					n.startup = 1'b1;
					n.cal_act = 1'b1;
					n.cal_req = 1'b0;
					n.cyc_ms = '0;
					n.cal_ph = 1'b0;
					n.cal_ch = next_cal(need, any_tc, 3'h0);
					to_cal = 1'b1;
				end
				scan_sched_pkg::ST_IDLE: begin
					to_scan = |en;
				end
				scan_sched_pkg::ST_CONV: begin
					if (step_end) begin
						if (!q.startup && !q.hold[q.idx[1:0]]) begin
							n.upd_valid = 1'b1;
							n.upd_chan = q.idx[1:0];
						end
						to_next = 1'b1;
					end
				end
				scan_sched_pkg::ST_CJ: begin
					to_eos = step_end;
				end
				scan_sched_pkg::ST_CAL: begin
					if (step_end) begin
						if (q.cal_ch != scan_sched_pkg::PTR_CJ && !q.cal_ph) begin
							n.cal_ph = 1'b1;
						end else if (q.cal_ch == scan_sched_pkg::PTR_CJ) begin
							n.cal_ch = scan_sched_pkg::PTR_DONE;
						end else begin
							n.cal_ph = 1'b0;
							n.cal_ch = next_cal(need, any_tc, 3'(q.cal_ch + 3'h1));
						end
						// Startup runs steps back to back; otherwise one step per scan
						if (q.startup) begin
							to_cal = 1'b1;
						end else begin
							to_scan = 1'b1;
							if (n.cal_ch == scan_sched_pkg::PTR_DONE) begin
								n.cal_act = 1'b0;
								if (!q.cal_req) begin
									n.hold = '0;
								end
							end
						end
					end
				end
				default: begin
					n.st = scan_sched_pkg::ST_PROG;
				end
			endcase
		end

		if (to_next) begin
			c = first_from(en, 3'(q.idx + 3'h1));
			if (c != scan_sched_pkg::PTR_NONE) begin
				launch = 1'b1;
				lch = c;
			end else if (any_tc) begin
				launch = 1'b1;
				lk = scan_sched_pkg::KIND_CJ;
				lch = scan_sched_pkg::PTR_CJ;
			end else begin
				to_eos = 1'b1;
			end
		end

		if (to_eos) begin
			if (!n.cal_act && n.cal_req) begin
				n.cal_act = 1'b1;
				n.cal_req = 1'b0;
				n.cyc_ms = '0;
				n.cal_ph = 1'b0;
				n.cal_ch = next_cal(need, any_tc, 3'h0);
			end
			to_cal = 1'b1;
		end

		if (to_cal) begin
			if (n.cal_act && n.cal_ch != scan_sched_pkg::PTR_DONE) begin
				launch = 1'b1;
				lch = n.cal_ch;
				lk = (n.cal_ph && n.cal_ch != scan_sched_pkg::PTR_CJ) ? scan_sched_pkg::KIND_OFFS
					: scan_sched_pkg::KIND_SELF;
			end else begin
				if (n.cal_act) begin
					n.cal_act = 1'b0;
					if (!n.cal_req) begin
						n.hold = '0;
					end
				end
				n.startup = 1'b0;
				to_scan = 1'b1;
			end
		end

		if (to_scan && !launch) begin
			n.last_scan = n.scan_ms;
			n.scan_ms = '0;
			c = first_from(en, 3'h0);
			if (c != scan_sched_pkg::PTR_NONE) begin
				launch = 1'b1;
				lch = c;
				lk = scan_sched_pkg::KIND_CONV;
			end else begin
				n.st = scan_sched_pkg::ST_IDLE;
			end
		end

		if (launch) begin
			lf = (lch == scan_sched_pkg::PTR_CJ) ? cj_filt : q.cfg[lch[1:0]][2:0];
			n.slot_start = 1'b1;
			n.slot_kind = lk;
			n.slot_chan = lch;
			n.slot_filter = lf;
			case (lk)
				scan_sched_pkg::KIND_CONV: begin
					n.st = scan_sched_pkg::ST_CONV;
					n.idx = lch;
					n.left = scan_sched_pkg::ms_of(scan_sched_pkg::SLOT_MS, lf);
				end
				scan_sched_pkg::KIND_CJ: begin
					n.st = scan_sched_pkg::ST_CJ;
					n.left = scan_sched_pkg::ms_of(scan_sched_pkg::SLOT_MS, lf);
				end
				scan_sched_pkg::KIND_SELF: begin
					n.st = scan_sched_pkg::ST_CAL;
					n.left = scan_sched_pkg::ms_of(scan_sched_pkg::SELF_MS, lf);
				end
				default: begin
					n.st = scan_sched_pkg::ST_CAL;
					n.left = scan_sched_pkg::ms_of(scan_sched_pkg::OFFS_MS, lf);
				end
			endcase
		end

		// Period timer; not counted during startup, so it does not fire right after it
		if (i_run_mode && q.st != scan_sched_pkg::ST_PROG && !q.startup && !q.cyc_dis && tick) begin
			if (n.cyc_ms >= 19'(P_CAL_PERIOD_MS - 1)) begin
				n.cyc_ms = '0;
				n.cal_req = 1'b1;
			end else begin
				n.cyc_ms = n.cyc_ms + 19'h00001;
			end
		end

		// Register writes come last so a new request wins over a clear in the same cycle
		if (i_wr) begin
			if (i_addr == scan_sched_pkg::REG_CTRL) begin
				n.cyc_dis = i_wdata[scan_sched_pkg::CTRL_CYC_DIS_BIT];
				if (q.cyc_dis && !i_wdata[scan_sched_pkg::CTRL_CYC_DIS_BIT]) begin
					n.cal_req = 1'b1;
				end
			end
			for (int i = 0; i < scan_sched_pkg::NUM_CH; i++) begin
				if (i_addr == 8'(scan_sched_pkg::REG_CFG0 + 8'(i) * scan_sched_pkg::REG_CFG_STEP)) begin
					n.cfg[i] = i_wdata[scan_sched_pkg::CFG_W-1:0];
					if (i_run_mode && q.st != scan_sched_pkg::ST_PROG && !q.startup
						&& i_wdata[scan_sched_pkg::CFG_W-1:0] != q.cfg[i]) begin
						n.hold[i] = 1'b1;
						n.cal_req = 1'b1;
					end
				end
			end
		end

		if (i_rd) begin
			case (i_addr)
				scan_sched_pkg::REG_CTRL: begin
					n.rdata[scan_sched_pkg::CTRL_CYC_DIS_BIT] = q.cyc_dis;
				end
				scan_sched_pkg::REG_STATUS: begin
					n.rdata[scan_sched_pkg::ST_CAL_BIT] = q.cal_act;
					n.rdata[scan_sched_pkg::ST_STARTUP_BIT] = q.startup;
					n.rdata[scan_sched_pkg::ST_RUN_BIT] = q.st != scan_sched_pkg::ST_PROG;
					n.rdata[scan_sched_pkg::ST_REQ_BIT] = q.cal_req;
					n.rdata[scan_sched_pkg::ST_HOLD_LSB +: 4] = q.hold;
					n.rdata[scan_sched_pkg::ST_INVALID_LSB +: 6] = {scan_sched_pkg::NUM_INVALID{q.startup}};
					n.rdata[scan_sched_pkg::ST_CHAN_LSB +: 3] = q.slot_chan;
				end
				scan_sched_pkg::REG_SCAN_MS: begin
					n.rdata[15:0] = q.last_scan;
				end
				default: begin
					for (int i = 0; i < scan_sched_pkg::NUM_CH; i++) begin
						if (i_addr == 8'(scan_sched_pkg::REG_CFG0 + 8'(i) * scan_sched_pkg::REG_CFG_STEP)) begin
							n.rdata[scan_sched_pkg::CFG_W-1:0] = q.cfg[i];
						end
					end
				end
			endcase
		end

		restart = launch;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= '0;
			q.st <= scan_sched_pkg::ST_PROG;
			q.cyc_dis <= scan_sched_pkg::CTRL_CYC_DIS_RST;
			q.cfg <= {scan_sched_pkg::NUM_CH{scan_sched_pkg::CFG_RST}};
		end else begin
			q <= n;
		end
	end

	// ==========================================
	// Outputs
	assign o_rdata = q.rdata;
	assign o_slot_start = q.slot_start;
	assign o_slot_kind = q.slot_kind;
	assign o_slot_chan = q.slot_chan;
	assign o_slot_filter = q.slot_filter;
	assign o_upd_valid = q.upd_valid;
	assign o_upd_chan = q.upd_chan;
	assign o_hold = q.hold;
	assign o_data_invalid = {scan_sched_pkg::NUM_INVALID{q.startup}};
	assign o_cal_busy = q.cal_act;
endmodule

/* File: testbench/plc_model.sv */
// Controller model that drives the register port of the scheduler
`timescale 1ns/1ps
module plc_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic i_we,
	input wire logic [7:0] i_a,
	input wire logic [31:0] i_d,
	output logic [7:0] o_addr,
	output logic [31:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	// ==========================================
	// Strobes and lines
	logic [7:0] last_a = 8'h00;
	logic [31:0] last_d = 32'h0;
	always @(posedge i_clk) begin
		if (i_go) begin
			last_a <= i_a;
			last_d <= i_d;
		end
	end
	// Released lines show the inverse of the last value so stale data cannot pass
	assign o_addr = i_go ? i_a : ~last_a;
	assign o_wdata = i_go ? i_d : ~last_d;
	assign o_wr = i_go & i_we;
	assign o_rd = i_go & ~i_we;
endmodule

/* File: testbench/scan_sched_monitor.sv */
// Checker of slot lengths and output relations of the scan scheduler
`timescale 1ns/1ps
module scan_sched_monitor #(
	parameter int P_CYC_PER_MS = scan_sched_pkg::CYC_PER_MS,
	parameter int P_CAL_PERIOD_MS = scan_sched_pkg::CAL_PERIOD_MS
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run_mode,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic o_slot_start,
	input wire logic [1:0] o_slot_kind,
	input wire logic [2:0] o_slot_chan,
	input wire logic [2:0] o_slot_filter,
	input wire logic o_upd_valid,
	input wire logic [1:0] o_upd_chan,
	input wire logic [5:0] o_data_invalid,
	input wire logic o_cal_busy
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========================================
	// Running slot, aborted slots are never judged
	localparam int T_CONV[6] = '{303, 63, 53, 15, 9, 7};
	localparam int T_SELF[6] = '{603, 123, 103, 27, 15, 9};
	localparam int T_OFFS[6] = '{303, 63, 53, 15, 9, 6};
	int cnt_q;
	logic ok_q;
	logic [1:0] kind_q;
	logic [2:0] chan_q;
	logic [2:0] filt_q;
	logic [2:0] f_c;
	assign f_c = (filt_q > 3'h5) ? 3'h0 : filt_q;
	always_ff @(posedge i_clk) begin
		cnt_q <= o_slot_start ? 1 : cnt_q + 1;
		ok_q <= i_rst_n && i_run_mode && (ok_q || o_slot_start);
		if (o_slot_start) begin
			kind_q <= o_slot_kind;
			chan_q <= o_slot_chan;
			filt_q <= o_slot_filter;
		end
	end
	sequence s_next_slot;
		o_slot_start && ok_q;
	endsequence
	sequence s_prog;
		!i_run_mode ##1 !i_run_mode;
	endsequence
	sequence s_no_rd;
		!i_rd ##1 1'b1;
	endsequence
	property p_conv_len;
		s_next_slot ##0 (kind_q == scan_sched_pkg::KIND_CONV) |-> cnt_q == T_CONV[f_c] * P_CYC_PER_MS;
	endproperty
	property p_cj_len;
		s_next_slot ##0 (kind_q == scan_sched_pkg::KIND_CJ) |-> cnt_q == T_CONV[f_c] * P_CYC_PER_MS;
	endproperty
	property p_self_len;
		s_next_slot ##0 (kind_q == scan_sched_pkg::KIND_SELF) |-> cnt_q == T_SELF[f_c] * P_CYC_PER_MS;
	endproperty
	property p_offs_len;
		s_next_slot ##0 (kind_q == scan_sched_pkg::KIND_OFFS) |-> cnt_q == T_OFFS[f_c] * P_CYC_PER_MS;
	endproperty
	property p_one_step;
		s_next_slot ##0 (kind_q[1] && o_data_invalid == 6'h00) |-> !o_slot_kind[1];
	endproperty
	property p_cal_busy;
		o_slot_start && o_slot_kind[1] |-> o_cal_busy;
	endproperty
	property p_cj_chan;
		o_slot_start && o_slot_kind == scan_sched_pkg::KIND_CJ |-> o_slot_chan == 3'h4;
	endproperty
	property p_upd_at_start;
		o_upd_valid |-> o_slot_start && kind_q == scan_sched_pkg::KIND_CONV && o_upd_chan == chan_q[1:0];
	endproperty
	property p_invalid_form;
		o_data_invalid != 6'h00 |-> o_data_invalid == 6'h3f && !o_upd_valid;
	endproperty
	property p_prog_quiet;
		s_prog |-> !o_slot_start && o_data_invalid == 6'h00;
	endproperty
	property p_rdata_idle;
		s_no_rd |-> o_rdata == 32'h0;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion slot length wrong");
	a_cj_len: assert property (p_cj_len) else $error("cold junction slot length wrong");
	a_self_len: assert property (p_self_len) else $error("self calibration length wrong");
	a_offs_len: assert property (p_offs_len) else $error("offset calibration length wrong");
	a_one_step: assert property (p_one_step) else $error("two calibration steps in one scan");
	a_cal_busy: assert property (p_cal_busy) else $error("calibration step outside a cycle");
	a_cj_chan: assert property (p_cj_chan) else $error("cold junction slot on a channel");
	a_upd_at_start: assert property (p_upd_at_start) else $error("data update out of place");
	a_invalid_form: assert property (p_invalid_form) else $error("invalid bits malformed");
	a_prog_quiet: assert property (p_prog_quiet) else $error("activity in program mode");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");
endmodule

bind scan_and_autocal_scheduler scan_sched_monitor #(.P_CYC_PER_MS(P_CYC_PER_MS), .P_CAL_PERIOD_MS(P_CAL_PERIOD_MS))
	u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_run_mode(i_run_mode), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_slot_start(o_slot_start), .o_slot_kind(o_slot_kind), .o_slot_chan(o_slot_chan), .o_slot_filter(o_slot_filter),
	.o_upd_valid(o_upd_valid), .o_upd_chan(o_upd_chan), .o_data_invalid(o_data_invalid), .o_cal_busy(o_cal_busy));

/* File: testbench/test_scan_and_autocal_scheduler.sv */
// Self-checking bench of the scan and autocalibration scheduler
`timescale 1ns/1ps
module test_scan_and_autocal_scheduler;
	// ==========================================
	// Signals and model state
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_run_mode = 1'b0;
	logic go = 1'b0;
	logic we = 1'b0;
	logic [7:0] a = 8'h00;
	logic [31:0] d = 32'h0;
	logic [7:0] i_addr;
	logic [31:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [31:0] o_rdata;
	logic o_slot_start;
	logic [1:0] o_slot_kind;
	logic [2:0] o_slot_chan;
	logic [2:0] o_slot_filter;
	logic o_upd_valid;
	logic [1:0] o_upd_chan;
	logic [5:0] o_data_invalid;
	logic [3:0] o_hold;
	logic [31:0] rnd = 32'h7d6d;
	logic [7:0] got;
	logic [7:0] exp_q[$];
	logic [7:0] cal_q[$];
	logic [4:0] cfg[4] = '{default: 5'h00};
	bit held[4];
	bit startup = 1'b0;
	bit prev_conv = 1'b0;
	int prev_ch = 0;
	int n_scans = 0;
	int k = 0;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	always #2 i_clk = ~i_clk;
	plc_model u_plc (.i_clk(i_clk), .i_go(go), .i_we(we), .i_a(a), .i_d(d), .o_addr(i_addr), .o_wdata(i_wdata),
		.o_wr(i_wr), .o_rd(i_rd));
	scan_and_autocal_scheduler #(.P_CYC_PER_MS(4), .P_CAL_PERIOD_MS(2000)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_run_mode(i_run_mode), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_slot_start(o_slot_start), .o_slot_kind(o_slot_kind), .o_slot_chan(o_slot_chan),
		.o_slot_filter(o_slot_filter), .o_upd_valid(o_upd_valid), .o_upd_chan(o_upd_chan), .o_hold(o_hold),
		.o_data_invalid(o_data_invalid), .o_cal_busy());
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	// Lowest-frequency thermocouple filter, 7 when none
	function automatic logic [2:0] cjf();
		logic [2:0] r = 3'h7;
		for (int c = 0; c < 4; c++) if (cfg[c][4] && cfg[c][3] && cfg[c][2:0] < r) r = cfg[c][2:0];
		return r;
	endfunction
	function automatic void load_cal();
		bit seen[8];
		cal_q = {};
		for (int c = 0; c < 4; c++) begin
			if (cfg[c][4] && !seen[cfg[c][2:0]]) begin
				seen[cfg[c][2:0]] = 1'b1;
				cal_q.push_back({scan_sched_pkg::KIND_SELF, 3'(c), cfg[c][2:0]});
				cal_q.push_back({scan_sched_pkg::KIND_OFFS, 3'(c), cfg[c][2:0]});
			end
		end
		if (cjf() != 3'h7) cal_q.push_back({scan_sched_pkg::KIND_SELF, 3'h4, cjf()});
	endfunction
	function automatic void load_scan();
		n_scans++;
		for (int c = 0; c < 4; c++) if (cfg[c][4]) exp_q.push_back({scan_sched_pkg::KIND_CONV, 3'(c), cfg[c][2:0]});
		if (cjf() != 3'h7) exp_q.push_back({scan_sched_pkg::KIND_CJ, 3'h4, cjf()});
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge i_clk);
		go <= 1'b1;
		we <= w;
		a <= adr;
		d <= dat;
		@(posedge i_clk);
		go <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, adr, 32'h0);
		@(negedge i_clk);
		chk("rdata", e, o_rdata & m);
	endtask
	task automatic start_run();
		load_cal();
		exp_q = {};
		prev_conv = 1'b0;
		startup = 1'b1;
		i_run_mode <= 1'b1;
	endtask
	task automatic end_of_test();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Every slot start is judged against the model; outside startup a cal step is only legal after a scan
	always @(negedge i_clk) begin
		if (i_rst_n && o_slot_start) begin
			got = {o_slot_kind, o_slot_chan, o_slot_filter};
			chk("upd_valid", {31'h0, prev_conv && !held[prev_ch]}, {31'h0, o_upd_valid});
			if (o_upd_valid === 1'b1) chk("upd_chan", prev_ch, {30'h0, o_upd_chan});
			chk("hold", {28'h0, held[3], held[2], held[1], held[0]}, {28'h0, o_hold});
			if (startup) begin
				chk("invalid", 32'h3f, {26'h0, o_data_invalid});
				chk("startup_slot", {24'h0, cal_q.pop_front()}, {24'h0, got});
				startup = (cal_q.size() != 0);
			end else if (exp_q.size() == 0 && got[7] && cal_q.size() != 0) begin
				chk("cal_step", {24'h0, cal_q.pop_front()}, {24'h0, got});
				if (cal_q.size() == 0) held = '{default: 1'b0};
			end else begin
				if (exp_q.size() == 0) load_scan();
				chk("scan_slot", {24'h0, exp_q.pop_front()}, {24'h0, got});
			end
			prev_conv = (got[7:6] == scan_sched_pkg::KIND_CONV);
			prev_ch = got[5:3];
		end
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(8'h00, 32'h1, 32'h0);
		bus(1'b1, 8'h00, 32'h1);
		rnd = xs(rnd);
		cfg = '{5'h1a, 5'h1a, 5'h13, {1'b1, rnd[3], 3'h5}};
		for (int c = 0; c < 4; c++) bus(1'b1, 8'(4 * c + 4), {27'h0, cfg[c]});
		start_run();
		repeat (10) @(posedge i_clk);
		rd(8'h14, 32'h3f02, 32'h3f02);
		wait (n_scans == 3);
		rd(8'h18, 32'hffff, 32'h000000b5);
		rnd = xs(rnd);
		rd(8'h1c + 8'(rnd % 200), 32'hffffffff, 32'h0);
		load_cal();
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h00, 32'h1);
		wait (cal_q.size() == 0);
		k = n_scans + 3;
		wait (n_scans >= k);
		wait (exp_q.size() == 0);
		cfg[2] = 5'h14;
		held[2] = 1'b1;
		load_cal();
		bus(1'b1, 8'h0c, 32'h14);
		wait (cal_q.size() == 0);
		// A request during the last step would keep the holds, so let the cycle end first
		k = n_scans + 1;
		wait (n_scans >= k);
		load_cal();
		bus(1'b1, 8'h00, 32'h0);
		wait (cal_q.size() == 0);
		load_cal();
		wait (cal_q.size() == 0);
		bus(1'b1, 8'h00, 32'h1);
		i_run_mode <= 1'b0;
		exp_q = {};
		repeat (20) @(posedge i_clk);
		start_run();
		wait (startup == 1'b0);
		k = n_scans + 2;
		wait (n_scans >= k);
		end_of_test();
	end
endmodule
